// *** tmc_pkg.sv ***
package tmc_pkg;

  // Register byte addresses.
  localparam logic [7:0] TMC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] TMC_ADDR_MODE = 8'h89;
  localparam logic [7:0] TMC_ADDR_A_LO = 8'h8A;
  localparam logic [7:0] TMC_ADDR_B_LO = 8'h8B;
  localparam logic [7:0] TMC_ADDR_A_HI = 8'h8C;
  localparam logic [7:0] TMC_ADDR_B_HI = 8'h8D;
  localparam logic [7:0] TMC_ADDR_CMP = 8'hCE;
  localparam logic [7:0] TMC_ADDR_PRESC = 8'hB2;

  // Field positions in timer_control.
  localparam int TMC_CTRL_FLAG_B = 7;
  localparam int TMC_CTRL_RUN_B = 6;
  localparam int TMC_CTRL_FLAG_A = 5;
  localparam int TMC_CTRL_RUN_A = 4;

  // Field positions in timer_mode_select; timer B nibble sits above timer A nibble.
  localparam int TMC_MODE_BASE_A = 0;
  localparam int TMC_MODE_BASE_B = 4;
  localparam int TMC_MODE_GATE = 3;
  localparam int TMC_MODE_SEL = 2;
  localparam int TMC_MODE_FLD = 0;

  // Compare enable bits, prescale field position and width masks.
  localparam int TMC_CMP_A = 0;
  localparam int TMC_CMP_B = 1;
  localparam logic [7:0] TMC_CMP_MASK = 8'h03;
  localparam int TMC_PRESC_LSB = 5;
  localparam logic [7:0] TMC_RESET_BYTE = 8'h00;
  localparam logic [7:0] TMC_BYTE_MAX = 8'hFF;
  localparam logic [4:0] TMC_LOW5_MAX = 5'h1F;
  localparam logic [7:0] TMC_BYTE_ONE = 8'h01;

  // Prescaler terminal counts for divide by 1, 2, 4 and 12.
  localparam logic [3:0] TMC_TERM_DIV1 = 4'h0;
  localparam logic [3:0] TMC_TERM_DIV2 = 4'h1;
  localparam logic [3:0] TMC_TERM_DIV4 = 4'h3;
  localparam logic [3:0] TMC_TERM_DIV12 = 4'hB;
  localparam logic [3:0] TMC_PRESC_ONE = 4'h1;

  // Index of each external input in the synchroniser vectors.
  localparam int TMC_IDX_PIN_A = 0;
  localparam int TMC_IDX_PIN_B = 1;
  localparam int TMC_IDX_IRQ_A = 2;
  localparam int TMC_IDX_IRQ_B = 3;
  localparam int TMC_NUM_IN = 4;

  typedef enum logic [1:0] {
    TMC_MODE_13 = 2'h0,
    TMC_MODE_16 = 2'h1,
    TMC_MODE_RELOAD = 2'h2,
    TMC_MODE_SPLIT = 2'h3
  } tmc_mode_t;

  typedef enum logic [1:0] {
    TMC_PS_DIV1 = 2'h0,
    TMC_PS_DIV2 = 2'h1,
    TMC_PS_DIV4 = 2'h2,
    TMC_PS_DIV12 = 2'h3
  } tmc_presc_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmc_bus_req_t;

  typedef struct packed {
    logic timer_a_pin;
    logic timer_b_pin;
    logic ext_irq_a_pin;
    logic ext_irq_b_pin;
  } tmc_pin_in_t;

  typedef struct packed {
    logic timer_a_pin_out;
    logic timer_a_pin_oe;
    logic timer_a_pin_pullup;
    logic timer_b_pin_out;
    logic timer_b_pin_oe;
    logic timer_b_pin_pullup;
    logic ext_irq_a_force_input;
    logic ext_irq_a_pullup;
    logic ext_irq_b_force_input;
    logic ext_irq_b_pullup;
  } tmc_pin_out_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic ovf;
  } tmc_step_t;

  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] timer_mode_select;
    logic [7:0] timer_a_count_low;
    logic [7:0] timer_a_count_high;
    logic [7:0] timer_b_count_low;
    logic [7:0] timer_b_count_high;
    logic [1:0] timer_compare_enable;
    tmc_presc_t sysclk_prescale_field;
    logic [3:0] presc_cnt;
    logic [TMC_NUM_IN-1:0] sync1;
    logic [TMC_NUM_IN-1:0] sync2;
    logic [TMC_NUM_IN-1:0] sync3;
    logic [TMC_NUM_IN-1:0] filt;
    logic [TMC_NUM_IN-1:0] filt_prev;
    logic [7:0] rdata;
    logic baud_pulse;
    tmc_pin_out_t pins;
  } tmc_state_t;

  localparam tmc_state_t TMC_STATE_RESET = '0;

endpackage : tmc_pkg

// *** tmc_dual_timer.sv ***
`timescale 1ns/1ps
module tmc_dual_timer
  import tmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire tmc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire tmc_pin_in_t pins_in,
  output tmc_pin_out_t pins_out,
  output logic timer_b_overflow
);

  tmc_state_t st_ff;
  tmc_state_t nxt_st;

  // One increment of a timer in the given mode; split mode only steps the low byte.
  function automatic tmc_step_t tmc_step(input tmc_mode_t mode, input logic [7:0] hi, input logic [7:0] lo);
    tmc_step_t r;
    r.hi = hi;
    r.lo = lo;
    r.ovf = 1'b0;
    unique case (mode)
      TMC_MODE_13: begin
        // The three top bits of the low byte are left alone, they carry no count.
        if (lo[4:0] == TMC_LOW5_MAX) begin
          r.lo[4:0] = '0;
          r.hi = hi + TMC_BYTE_ONE;
          r.ovf = (hi == TMC_BYTE_MAX);
        end else begin
          r.lo[4:0] = lo[4:0] + TMC_BYTE_ONE[4:0];
        end
      end
      TMC_MODE_16: begin
        r.lo = lo + TMC_BYTE_ONE;
        if (lo == TMC_BYTE_MAX) begin
          r.hi = hi + TMC_BYTE_ONE;
          r.ovf = (hi == TMC_BYTE_MAX);
        end
      end
      TMC_MODE_RELOAD: begin
        if (lo == TMC_BYTE_MAX) begin
          r.lo = hi;
          r.ovf = 1'b1;
        end else begin
          r.lo = lo + TMC_BYTE_ONE;
        end
      end
      TMC_MODE_SPLIT: begin
        r.lo = lo + TMC_BYTE_ONE;
        r.ovf = (lo == TMC_BYTE_MAX);
      end
    endcase
    return r;
  endfunction : tmc_step

  // Next-state logic for the whole block.
  always_comb begin
    logic [TMC_NUM_IN-1:0] fall;
    logic [3:0] term;
    logic tick;
    logic run_a;
    logic run_b;
    logic gate_a;
    logic gate_b;
    logic sel_a;
    logic sel_b;
    tmc_mode_t mode_a;
    tmc_mode_t mode_b;
    logic split;
    logic inc_a;
    logic inc_ah;
    logic inc_b;
    logic ovf_a;
    logic ovf_ah;
    logic ovf_b;
    logic set_a;
    logic set_b;
    tmc_step_t step_a;
    tmc_step_t step_b;
    fall = '0;
    term = TMC_TERM_DIV1;
    tick = 1'b0;
    run_a = 1'b0;
    run_b = 1'b0;
    gate_a = 1'b0;
    gate_b = 1'b0;
    sel_a = 1'b0;
    sel_b = 1'b0;
    mode_a = TMC_MODE_13;
    mode_b = TMC_MODE_13;
    split = 1'b0;
    inc_a = 1'b0;
    inc_ah = 1'b0;
    inc_b = 1'b0;
    ovf_a = 1'b0;
    ovf_ah = 1'b0;
    ovf_b = 1'b0;
    set_a = 1'b0;
    set_b = 1'b0;
    step_a = '0;
    step_b = '0;
    nxt_st = st_ff;

    // Three-stage synchroniser; the filtered level moves only when stages two and three agree.
    nxt_st.sync1 = {pins_in.ext_irq_b_pin, pins_in.ext_irq_a_pin, pins_in.timer_b_pin, pins_in.timer_a_pin};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    nxt_st.filt_prev = st_ff.filt;
    for (int i = 0; i < TMC_NUM_IN; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        nxt_st.filt[i] = st_ff.sync3[i];
      end
      fall[i] = st_ff.filt_prev[i] & ~st_ff.filt[i];
    end

    // Prescaler: tick is the system clock enable that the timers count in timer mode.
    unique case (st_ff.sysclk_prescale_field)
      TMC_PS_DIV1: term = TMC_TERM_DIV1;
      TMC_PS_DIV2: term = TMC_TERM_DIV2;
      TMC_PS_DIV4: term = TMC_TERM_DIV4;
      TMC_PS_DIV12: term = TMC_TERM_DIV12;
    endcase
    tick = (st_ff.presc_cnt >= term);
    nxt_st.presc_cnt = tick ? '0 : st_ff.presc_cnt + TMC_PRESC_ONE;

    // Decode control fields.
    run_a = st_ff.timer_control[TMC_CTRL_RUN_A];
    run_b = st_ff.timer_control[TMC_CTRL_RUN_B];
    gate_a = st_ff.timer_mode_select[TMC_MODE_BASE_A + TMC_MODE_GATE];
    gate_b = st_ff.timer_mode_select[TMC_MODE_BASE_B + TMC_MODE_GATE];
    sel_a = st_ff.timer_mode_select[TMC_MODE_BASE_A + TMC_MODE_SEL];
    sel_b = st_ff.timer_mode_select[TMC_MODE_BASE_B + TMC_MODE_SEL];
    mode_a = tmc_mode_t'(st_ff.timer_mode_select[TMC_MODE_BASE_A + TMC_MODE_FLD +: 2]);
    mode_b = tmc_mode_t'(st_ff.timer_mode_select[TMC_MODE_BASE_B + TMC_MODE_FLD +: 2]);
    split = (mode_a == TMC_MODE_SPLIT);

    // Timer A: run and gate qualify the chosen source; a high gate input counts as active.
    inc_a = run_a & (~gate_a | st_ff.filt[TMC_IDX_IRQ_A]) & (sel_a ? fall[TMC_IDX_PIN_A] : tick);
    step_a = tmc_step(mode_a, st_ff.timer_a_count_high, st_ff.timer_a_count_low);
    ovf_a = inc_a & step_a.ovf;

    // Split high byte borrows timer B's run bit and flag and only sees the system clock.
    inc_ah = split & run_b & tick;
    ovf_ah = inc_ah & (st_ff.timer_a_count_high == TMC_BYTE_MAX);

    // Timer B: with A split it runs by mode alone on the system clock; mode 3 always stops it.
    if (split) begin
      inc_b = (mode_b != TMC_MODE_SPLIT) & tick;
    end else begin
      inc_b = run_b & (mode_b != TMC_MODE_SPLIT) & (~gate_b | st_ff.filt[TMC_IDX_IRQ_B]) &
              (sel_b ? fall[TMC_IDX_PIN_B] : tick);
    end
    step_b = tmc_step(mode_b, st_ff.timer_b_count_high, st_ff.timer_b_count_low);
    ovf_b = inc_b & step_b.ovf;
    nxt_st.baud_pulse = ovf_b;

    // Count updates; the count is only ever changed by increments or writes.
    if (inc_a) begin
      nxt_st.timer_a_count_low = step_a.lo;
      if (!split) begin
        nxt_st.timer_a_count_high = step_a.hi;
      end
    end
    if (inc_ah) begin
      nxt_st.timer_a_count_high = st_ff.timer_a_count_high + TMC_BYTE_ONE;
    end
    if (inc_b) begin
      nxt_st.timer_b_count_low = step_b.lo;
      nxt_st.timer_b_count_high = step_b.hi;
    end

    // Flag set sources; in split mode timer B's own overflow no longer reaches its flag.
    set_a = ovf_a;
    set_b = split ? ovf_ah : ovf_b;

    // Compare output toggles on each overflow; sharing pins with the split high byte is not modelled.
    if (ovf_a & st_ff.timer_compare_enable[TMC_CMP_A]) begin
      nxt_st.pins.timer_a_pin_out = ~st_ff.pins.timer_a_pin_out;
    end
    if (ovf_b & st_ff.timer_compare_enable[TMC_CMP_B]) begin
      nxt_st.pins.timer_b_pin_out = ~st_ff.pins.timer_b_pin_out;
    end

    // Register writes win over increments to the same byte.
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        TMC_ADDR_CTRL: nxt_st.timer_control = bus_req.wdata;
        TMC_ADDR_MODE: nxt_st.timer_mode_select = bus_req.wdata;
        TMC_ADDR_A_LO: nxt_st.timer_a_count_low = bus_req.wdata;
        TMC_ADDR_A_HI: nxt_st.timer_a_count_high = bus_req.wdata;
        TMC_ADDR_B_LO: nxt_st.timer_b_count_low = bus_req.wdata;
        TMC_ADDR_B_HI: nxt_st.timer_b_count_high = bus_req.wdata;
        TMC_ADDR_CMP: nxt_st.timer_compare_enable = bus_req.wdata[TMC_CMP_B:TMC_CMP_A];
        TMC_ADDR_PRESC: nxt_st.sysclk_prescale_field = tmc_presc_t'(bus_req.wdata[TMC_PRESC_LSB +: 2]);
        default: ;
      endcase
    end

    // Hardware set beats a software clear in the same cycle, so no overflow is lost.
    nxt_st.timer_control[TMC_CTRL_FLAG_A] = nxt_st.timer_control[TMC_CTRL_FLAG_A] | set_a;
    nxt_st.timer_control[TMC_CTRL_FLAG_B] = nxt_st.timer_control[TMC_CTRL_FLAG_B] | set_b;

    // Pin controls follow the new register values, so they settle the cycle after a write.
    nxt_st.pins.timer_a_pin_oe = nxt_st.timer_compare_enable[TMC_CMP_A];
    nxt_st.pins.timer_b_pin_oe = nxt_st.timer_compare_enable[TMC_CMP_B];
    nxt_st.pins.timer_a_pin_pullup = nxt_st.timer_control[TMC_CTRL_RUN_A] &
                                     nxt_st.timer_mode_select[TMC_MODE_BASE_A + TMC_MODE_SEL];
    nxt_st.pins.timer_b_pin_pullup = nxt_st.timer_control[TMC_CTRL_RUN_B] &
                                     nxt_st.timer_mode_select[TMC_MODE_BASE_B + TMC_MODE_SEL] &
                                     (nxt_st.timer_mode_select[TMC_MODE_BASE_A + TMC_MODE_FLD +: 2] !=
                                      TMC_MODE_SPLIT);
    nxt_st.pins.ext_irq_a_force_input = nxt_st.timer_control[TMC_CTRL_RUN_A] &
                                        nxt_st.timer_mode_select[TMC_MODE_BASE_A + TMC_MODE_GATE];
    nxt_st.pins.ext_irq_a_pullup = nxt_st.pins.ext_irq_a_force_input;
    nxt_st.pins.ext_irq_b_force_input = nxt_st.timer_control[TMC_CTRL_RUN_B] &
                                        nxt_st.timer_mode_select[TMC_MODE_BASE_B + TMC_MODE_GATE];
    nxt_st.pins.ext_irq_b_pullup = nxt_st.pins.ext_irq_b_force_input;

    // Read data stand for exactly one cycle after the strobe; unmapped addresses read zero.
    nxt_st.rdata = TMC_RESET_BYTE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        TMC_ADDR_CTRL: nxt_st.rdata = st_ff.timer_control;
        TMC_ADDR_MODE: nxt_st.rdata = st_ff.timer_mode_select;
        TMC_ADDR_A_LO: nxt_st.rdata = st_ff.timer_a_count_low;
        TMC_ADDR_A_HI: nxt_st.rdata = st_ff.timer_a_count_high;
        TMC_ADDR_B_LO: nxt_st.rdata = st_ff.timer_b_count_low;
        TMC_ADDR_B_HI: nxt_st.rdata = st_ff.timer_b_count_high;
        TMC_ADDR_CMP: nxt_st.rdata = {6'h00, st_ff.timer_compare_enable} & TMC_CMP_MASK;
        TMC_ADDR_PRESC: nxt_st.rdata = {1'b0, st_ff.sysclk_prescale_field, 5'h00};
        default: nxt_st.rdata = TMC_RESET_BYTE;
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= TMC_STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus_rdata = st_ff.rdata;
  assign pins_out = st_ff.pins;
  assign timer_b_overflow = st_ff.baud_pulse;

endmodule : tmc_dual_timer

// *** tmc_dual_timer_chk.sv ***
`timescale 1ns/1ps
module tmc_dual_timer_chk
  import tmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire tmc_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire tmc_pin_in_t pins_in,
  input wire tmc_pin_out_t pins_out,
  input wire logic timer_b_overflow
);
  // Every check lives in the one clock domain and is muted while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Register read-back shapes: unused bits must read as zero.
  chk_cmp_upper_zero: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == TMC_ADDR_CMP |-> bus_rdata[7:2] == 6'h00)
    else $error("compare enable upper bits not zero");
  chk_presc_read_mask: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == TMC_ADDR_PRESC |-> (bus_rdata & 8'h9F) == 8'h00)
    else $error("prescale register shows bits outside its field");
  // A control write read back two cycles later keeps its storage bits, and flag A set by it stays set.
  chk_ctrl_write_back: assert property (
    $past(bus_req.wr, 3) && $past(bus_req.addr, 3) == TMC_ADDR_CTRL && !$past(bus_req.wr, 2)
    && $past(rst_n) && $past(rst_n, 2) && $past(bus_req.rd) && $past(bus_req.addr) == TMC_ADDR_CTRL
    |-> bus_rdata[3:0] == $past(bus_req.wdata[3:0], 3) && (bus_rdata[5] || !$past(bus_req.wdata[5], 3)))
    else $error("control register read back differs from write");
  // Drive enables change at the same edge as the compare register, so a lagging enable is caught.
  chk_oe_a_follow: assert property (
    $past(bus_req.wr) && $past(bus_req.addr) == TMC_ADDR_CMP |-> pins_out.timer_a_pin_oe == $past(bus_req.wdata[0]))
    else $error("timer a drive enable does not follow compare bit");
  chk_oe_b_follow: assert property (
    $past(bus_req.wr) && $past(bus_req.addr) == TMC_ADDR_CMP |-> pins_out.timer_b_pin_oe == $past(bus_req.wdata[1]))
    else $error("timer b drive enable does not follow compare bit");
  // A compare pin may only move while the device drives it.
  chk_toggle_a_driven: assert property (
    $changed(pins_out.timer_a_pin_out) |-> pins_out.timer_a_pin_oe)
    else $error("timer a pin toggled while not driven");
  chk_toggle_b_driven: assert property (
    $changed(pins_out.timer_b_pin_out) |-> pins_out.timer_b_pin_oe)
    else $error("timer b pin toggled while not driven");
  // The gate pin is turned to input and pulled up together, never one without the other.
  chk_irq_a_pair: assert property (
    pins_out.ext_irq_a_force_input == pins_out.ext_irq_a_pullup)
    else $error("gate a input and pull-up disagree");
  chk_irq_b_pair: assert property (
    pins_out.ext_irq_b_force_input == pins_out.ext_irq_b_pullup)
    else $error("gate b input and pull-up disagree");
endmodule : tmc_dual_timer_chk

bind tmc_dual_timer tmc_dual_timer_chk u_chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pins_in(pins_in), .pins_out(pins_out), .timer_b_overflow(timer_b_overflow));

// *** dual_timer_counter_compare_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, a); end end
module dual_timer_counter_compare_tb
  import tmc_pkg::*;
;
  typedef struct {
    string n;
    logic [7:0] v;
  } tmc_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tmc_bus_req_t bus_req = '0;
  tmc_pin_in_t pins_in = 4'hC;
  logic [7:0] bus_rdata;
  tmc_pin_out_t pins_out;
  logic timer_b_overflow;
  logic rd_pend = 1'b0;
  logic [31:0] lfsr = 32'hF036;
  logic [7:0] adr [9] = '{TMC_ADDR_CTRL, TMC_ADDR_MODE, TMC_ADDR_A_LO, TMC_ADDR_B_LO, TMC_ADDR_A_HI,
    TMC_ADDR_B_HI, TMC_ADDR_CMP, TMC_ADDR_PRESC, 8'h90};
  int num_errors = 0;
  int tests_run = 0;
  int ovf_cnt = 0;
  tmc_note_t q [$];
  tmc_note_t nt;

  tmc_dual_timer DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pins_in(pins_in), .pins_out(pins_out), .timer_b_overflow(timer_b_overflow));

  // The 40 ns clock.
  initial begin
    forever #20 clk = ~clk;
  end

  // Read data stand only in the cycle after the strobe, so the oldest note is compared exactly then.
  always @(posedge clk) begin
    if (rd_pend) begin
      nt = q.pop_front();
      `CHK(nt.n, nt.v, bus_rdata)
    end
    if (timer_b_overflow === 1'b1) begin
      ovf_cnt++;
    end
    rd_pend <= bus_req.rd;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // The note is queued when the strobe goes out and matched two edges later.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    q.push_back('{n, e});
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
  endtask : rd

  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input string n);
    wr(a, d);
    rd(a, e, n);
  endtask : wr_rd

  // Runs for five ticks at divide by one; the control read in the middle sees the first two.
  task automatic run(input logic [7:0] on, input logic [7:0] exp_ctrl);
    wr(TMC_ADDR_CTRL, on);
    @(posedge clk);
    rd(TMC_ADDR_CTRL, exp_ctrl, "ctrl");
    wr(TMC_ADDR_CTRL, 8'h00);
  endtask : run

  // Falling edges are spaced well below half the clock rate, as the synchroniser needs.
  task automatic fall(input int k);
    repeat (k) begin
      @(posedge clk);
      pins_in.timer_a_pin <= 1'b0;
      repeat (4) @(posedge clk);
      pins_in.timer_a_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : fall

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic conclude;
    repeat (3) @(posedge clk);
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (adr[i]) rd(adr[i], 8'h00, "reset value");
    wr_rd(TMC_ADDR_CTRL, 8'hAF, 8'hAF, "ctrl");
    wr_rd(TMC_ADDR_CMP, 8'hFF, 8'h03, "cmp");
    wr_rd(TMC_ADDR_PRESC, 8'hFF, 8'h60, "presc");
    wr(TMC_ADDR_PRESC, 8'h00);
    wr(TMC_ADDR_CTRL, 8'h00);
    done("registers");
    wr(TMC_ADDR_MODE, 8'h00);
    wr(TMC_ADDR_A_LO, 8'hFE);
    wr(TMC_ADDR_A_HI, 8'hFF);
    run(8'h10, 8'h30);
    rd(TMC_ADDR_A_LO, 8'hE3, "a lo");
    rd(TMC_ADDR_A_HI, 8'h00, "a hi");
    `CHK("pin a", 2'b11, {pins_out.timer_a_pin_out, pins_out.timer_a_pin_oe})
    done("thirteen bit");
    ovf_cnt = 0;
    wr(TMC_ADDR_MODE, 8'h10);
    wr(TMC_ADDR_B_LO, 8'hFE);
    wr(TMC_ADDR_B_HI, 8'hFF);
    run(8'h40, 8'hC0);
    rd(TMC_ADDR_B_LO, 8'h03, "b lo");
    rd(TMC_ADDR_B_HI, 8'h00, "b hi");
    `CHK("b overflow pulses", 1, ovf_cnt)
    `CHK("pin b", 1'b1, pins_out.timer_b_pin_out)
    done("sixteen bit");
    wr(TMC_ADDR_MODE, 8'h12);
    wr(TMC_ADDR_A_LO, 8'hFE);
    wr(TMC_ADDR_A_HI, 8'hA5);
    run(8'h10, 8'h30);
    rd(TMC_ADDR_A_LO, 8'hA8, "a lo");
    rd(TMC_ADDR_A_HI, 8'hA5, "a hi");
    `CHK("pin a", 1'b0, pins_out.timer_a_pin_out)
    done("reload");
    wr(TMC_ADDR_CMP, 8'h00);
    wr(TMC_ADDR_MODE, 8'h03);
    wr(TMC_ADDR_A_LO, 8'h10);
    wr(TMC_ADDR_A_HI, 8'hFE);
    run(8'h40, 8'hC0);
    rd(TMC_ADDR_A_HI, 8'h03, "a hi");
    rd(TMC_ADDR_A_LO, 8'h10, "a lo");
    `CHK("oe a", 1'b0, pins_out.timer_a_pin_oe)
    done("split");
    // Counter mode with the gate shut first, then open.
    wr(TMC_ADDR_MODE, 8'h0D);
    wr(TMC_ADDR_A_LO, 8'h00);
    wr(TMC_ADDR_A_HI, 8'h00);
    wr(TMC_ADDR_CTRL, 8'h10);
    fall(3);
    rd(TMC_ADDR_A_LO, 8'h00, "gated count");
    `CHK("irq a input", 1'b1, pins_out.ext_irq_a_force_input)
    `CHK("pin a pull-up", 1'b1, pins_out.timer_a_pin_pullup)
    pins_in.ext_irq_a_pin <= 1'b1;
    repeat (8) @(posedge clk);
    fall(3);
    repeat (8) @(posedge clk);
    rd(TMC_ADDR_A_LO, 8'h03, "edge count");
    done("counter");
    // Random loads into a running timer must land, then resume counting from there.
    wr(TMC_ADDR_MODE, 8'h01);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      wr_rd(TMC_ADDR_A_LO, lfsr[15:8], lfsr[15:8] + 8'h01, "loaded count");
    end
    // Divide by four: the prescaler starts from zero, so ticks land on every fourth edge after the write.
    wr(TMC_ADDR_PRESC, 8'h40);
    wr(TMC_ADDR_A_LO, 8'h10);
    rd(TMC_ADDR_A_LO, 8'h10, "div four");
    rd(TMC_ADDR_A_LO, 8'h11, "div four");
    rd(TMC_ADDR_A_LO, 8'h11, "div four");
    rd(TMC_ADDR_A_LO, 8'h12, "div four");
    wr(TMC_ADDR_CTRL, 8'h00);
    done("load while running");
    conclude();
  end

  // A hang is cut short here.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("unexpected run length exp finished got timeout");
    conclude();
  end
endmodule : dual_timer_counter_compare_tb
